// ---- src/dcs_pkg.sv ----
package dcs_pkg;

  // Sample and word geometry
  localparam int SMP_W   = 16;
  localparam int PHASES  = 5;
  localparam int WORD_W  = 80;
  localparam int CPLX_W  = 32;
  localparam int STAGE_W = 3;
  localparam int CNT_W   = 7;
  localparam int PH_W    = 16;
  localparam int LUT_AW  = 4;
  localparam int CMB_W   = 3;

  // Oscillator: the top four phase bits index the cosine table
  localparam logic [LUT_AW-1:0] QUARTER_TURN = 4'h4;

  // One fifth in Q16, the gain of the five-sample decimator average
  localparam logic [15:0] DEC5_GAIN = 16'h3333;

  // Combiner fill levels in halves: a word completes at EXACT or SPLIT; ONE is the leftover after a split, TWO the step per sample
  localparam logic [CMB_W-1:0] CMB_EXACT = 3'h3;
  localparam logic [CMB_W-1:0] CMB_SPLIT = 3'h4;
  localparam logic [CMB_W-1:0] CMB_ONE   = 3'h1;
  localparam logic [CMB_W-1:0] CMB_TWO   = 3'h2;

  // Side-band flag: the word starts with the imaginary half of a split sample
  localparam logic SPLIT_AT_MSB = 1'b0;
  localparam logic SPLIT_AT_LSB = 1'b1;

  // Complex sample: real part in the low half, so real precedes imaginary in memory
  typedef struct packed {
    logic signed [SMP_W-1:0] im;
    logic signed [SMP_W-1:0] re;
  } dcs_cplx_t;

  typedef dcs_cplx_t [PHASES-1:0]               dcs_cplx5_t;
  typedef logic signed [PHASES-1:0][SMP_W-1:0] dcs_real5_t;

  // Cosine over one turn, Q15
  localparam logic signed [SMP_W-1:0] COS_LUT [16] = '{
    16'h7FFF, 16'h7642, 16'h5A82, 16'h30FC, 16'h0000, 16'hCF04, 16'hA57E, 16'h89BE,
    16'h8001, 16'h89BE, 16'hA57E, 16'hCF04, 16'h0000, 16'h30FC, 16'h5A82, 16'h7642
  };

  // Interpolation weights k/5 in Q16 for the five output phases
  localparam logic [17:0] FIFTH_W [PHASES] = '{
    18'h0_0000, 18'h0_3333, 18'h0_6666, 18'h0_9999, 18'h0_CCCC
  };

endpackage

// ---- src/dcs_sample_chain.sv ----
`timescale 1ns/10ps
module dcs_sample_chain import dcs_pkg::*; (
  input  wire logic                   core_clk_in,
  input  wire logic                   nrst_in,
  input  wire logic [PH_W-1:0]        dc_step_in,
  input  wire logic [PH_W-1:0]        uc_step_in,
  input  wire logic [STAGE_W-1:0]     decim_stages_in,
  input  wire logic [STAGE_W-1:0]     interp_stages_in,
  input  wire dcs_real5_t             adc_tdata_in,
  input  wire logic                   adc_tvalid_in,
  output logic                        adc_tready_out,
  output logic [WORD_W-1:0]           acq_tdata_out,
  output logic                        acq_tuser_out,
  output logic                        acq_tvalid_out,
  input  wire logic                   acq_tready_in,
  output logic                        acq_overrun_out,
  input  wire dcs_cplx_t              str_tdata_in,
  input  wire logic                   str_tvalid_in,
  output logic                        str_tready_out,
  output dcs_real5_t                  dac_tdata_out,
  output logic                        dac_tvalid_out,
  input  wire logic                   dac_tready_in
);

  // Receive state
  logic [PH_W-1:0]          dacc_q, dacc_d;
  dcs_cplx5_t               mix_q, mix_d, mix_w;
  logic                     mixv_q, mixv_d;
  dcs_cplx_t                d5_q, d5_d;
  logic                     d5v_q, d5v_d;
  logic signed [22:0]       pre_q, pre_d, pim_q, pim_d;
  logic [CNT_W-1:0]         pcnt_q, pcnt_d;
  dcs_cplx_t                p2_q, p2_d;
  logic                     p2v_q, p2v_d;
  logic [63:0]              cbuf_q, cbuf_d;
  logic [CMB_W-1:0]         ccnt_q, ccnt_d;
  logic [WORD_W-1:0]        acq_d;
  logic                     acqu_d, acqv_d, ovr_d;

  // Transmit state
  logic [PH_W-1:0]          uacc_q, uacc_d;
  dcs_cplx_t                cur_q, cur_d, nxt_q, nxt_d, prev_q, prev_d, tx_smp;
  logic                     curv_q, curv_d, nxtv_q, nxtv_d, strr_d;
  logic [CNT_W-1:0]         rep_q, rep_d;
  dcs_cplx5_t               i5_q, i5_d, i5_w;
  dcs_real5_t               dac_d, dac_w;

  // Zero-order underflow: an empty holding slot feeds zeros instead of stale data
  assign tx_smp = curv_q ? cur_q : '0;

  // Per-phase oscillator, mixers and interpolation; one slice per sample phase of the word
  for (genvar k = 0; k < PHASES; k++) begin : g_phase
    logic [PH_W-1:0]         dph, uph;
    logic [LUT_AW-1:0]       di, ui;
    logic signed [SMP_W:0]   dnsin, unsin;
    logic signed [31:0]      dre_p, uc_p;
    logic signed [32:0]      dim_p, us_p;
    logic signed [33:0]      usum;
    logic signed [SMP_W:0]   dre17, dim17;
    logic signed [36:0]      ire_p, iim_p;
    logic signed [17:0]      ire_s, iim_s;

    assign dph   = PH_W'(dacc_q + PH_W'(PH_W'(k) * dc_step_in));
    assign uph   = PH_W'(uacc_q + PH_W'(PH_W'(k) * uc_step_in));
    assign di    = dph[PH_W-1 -: LUT_AW];
    assign ui    = uph[PH_W-1 -: LUT_AW];
    assign dnsin = -{COS_LUT[LUT_AW'(di - QUARTER_TURN)][SMP_W-1],
                     COS_LUT[LUT_AW'(di - QUARTER_TURN)]};
    assign unsin = -{COS_LUT[LUT_AW'(ui - QUARTER_TURN)][SMP_W-1],
                     COS_LUT[LUT_AW'(ui - QUARTER_TURN)]};

    // Real input times cos and -sin gives the complex baseband product
    // One phase selected from the packed word loses its sign, so restore it
    assign dre_p        = $signed(adc_tdata_in[k]) * COS_LUT[di];
    assign dim_p        = $signed(adc_tdata_in[k]) * dnsin;
    assign mix_w[k].re  = dre_p[30:15];
    assign mix_w[k].im  = dim_p[30:15];

    // Linear ramp between two inputs: zero-stuffing followed by a triangle low-pass
    assign dre17        = {tx_smp.re[SMP_W-1], tx_smp.re} - {prev_q.re[SMP_W-1], prev_q.re};
    assign dim17        = {tx_smp.im[SMP_W-1], tx_smp.im} - {prev_q.im[SMP_W-1], prev_q.im};
    assign ire_p        = dre17 * $signed({1'b0, FIFTH_W[k]});
    assign iim_p        = dim17 * $signed({1'b0, FIFTH_W[k]});
    assign ire_s        = {prev_q.re[SMP_W-1], prev_q.re[SMP_W-1], prev_q.re} + 18'(ire_p[33:16]);
    assign iim_s        = {prev_q.im[SMP_W-1], prev_q.im[SMP_W-1], prev_q.im} + 18'(iim_p[33:16]);
    assign i5_w[k].re   = ire_s[15:0];
    assign i5_w[k].im   = iim_s[15:0];

    // Only the real part of the complex product leaves the up mixer; wraps on overflow
    assign uc_p         = i5_q[k].re * COS_LUT[ui];
    assign us_p         = i5_q[k].im * unsin;
    assign usum         = 34'(uc_p) + 34'(us_p);
    assign dac_w[k]     = usum[30:15];
  end

  // Receive chain next state: every stage moves on forward valid alone
  always_comb begin
    logic signed [18:0]     sre, sim;
    logic signed [35:0]     gre, gim;
    logic signed [22:0]     are, aim;
    logic [CNT_W-1:0]       plast;
    dcs_cplx_t              s;
    sre    = '0;
    sim    = '0;
    gre    = '0;
    gim    = '0;
    are    = '0;
    aim    = '0;
    s      = p2_q;
    plast  = CNT_W'((8'h01 << decim_stages_in) - 8'h01);
    dacc_d = dacc_q;
    mix_d  = mix_q;
    mixv_d = adc_tvalid_in;
    d5_d   = d5_q;
    d5v_d  = mixv_q;
    pre_d  = pre_q;
    pim_d  = pim_q;
    pcnt_d = pcnt_q;
    p2_d   = p2_q;
    p2v_d  = 1'b0;
    cbuf_d = cbuf_q;
    ccnt_d = ccnt_q;
    acq_d  = acq_tdata_out;
    acqu_d = acq_tuser_out;
    acqv_d = 1'b0;
    ovr_d  = acq_overrun_out | (acq_tvalid_out & ~acq_tready_in);
    // Oscillator advances five sample phases per accepted word
    if (adc_tvalid_in) begin
      dacc_d = PH_W'(dacc_q + PH_W'(PH_W'(PHASES) * dc_step_in));
      mix_d  = mix_w;
    end
    // Five-sample average per component, one complex sample per clock out
    if (mixv_q) begin
      for (int k = 0; k < PHASES; k++) begin
        sre = sre + 19'(mix_q[k].re);
        sim = sim + 19'(mix_q[k].im);
      end
      gre     = sre * $signed({1'b0, DEC5_GAIN});
      gim     = sim * $signed({1'b0, DEC5_GAIN});
      d5_d.re = gre[31:16];
      d5_d.im = gim[31:16];
    end
    // Boxcar over 2^N samples; N of zero hands every sample straight on
    if (d5v_q) begin
      are    = ((pcnt_q == '0) ? 23'sd0 : pre_q) + 23'(d5_q.re);
      aim    = ((pcnt_q == '0) ? 23'sd0 : pim_q) + 23'(d5_q.im);
      pre_d  = are;
      pim_d  = aim;
      if (pcnt_q == plast) begin
        are     = are >>> decim_stages_in;
        aim     = aim >>> decim_stages_in;
        p2_d.re = are[15:0];
        p2_d.im = aim[15:0];
        p2v_d   = 1'b1;
        pcnt_d  = '0;
      end else begin
        pcnt_d = CNT_W'(pcnt_q + 1'b1);
      end
    end
    // Halfword packer: five halves per word, real before imaginary, low first
    if (p2v_q) begin
      if (ccnt_q == CMB_SPLIT) begin
        acq_d          = {s.re, cbuf_q};
        acqu_d         = SPLIT_AT_MSB;
        acqv_d         = 1'b1;
        cbuf_d         = '0;
        cbuf_d[15:0]   = s.im;
        ccnt_d         = CMB_ONE;
      end else if (ccnt_q == CMB_EXACT) begin
        acq_d          = {s, cbuf_q[47:0]};
        acqu_d         = SPLIT_AT_LSB;
        acqv_d         = 1'b1;
        cbuf_d         = '0;
        ccnt_d         = '0;
      end else begin
        cbuf_d[ccnt_q*16 +: 32] = s;
        ccnt_d                  = CMB_W'(ccnt_q + CMB_TWO);
      end
    end
  end

  // Receive registers; ready to the converter is low in reset, then held high from the first clock after
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      adc_tready_out  <= 1'b0;
      dacc_q          <= '0;
      mix_q           <= '0;
      mixv_q          <= 1'b0;
      d5_q            <= '0;
      d5v_q           <= 1'b0;
      pre_q           <= '0;
      pim_q           <= '0;
      pcnt_q          <= '0;
      p2_q            <= '0;
      p2v_q           <= 1'b0;
      cbuf_q          <= '0;
      ccnt_q          <= '0;
      acq_tdata_out   <= '0;
      acq_tuser_out   <= 1'b0;
      acq_tvalid_out  <= 1'b0;
      acq_overrun_out <= 1'b0;
    end else begin
      adc_tready_out  <= 1'b1;
      dacc_q          <= dacc_d;
      mix_q           <= mix_d;
      mixv_q          <= mixv_d;
      d5_q            <= d5_d;
      d5v_q           <= d5v_d;
      pre_q           <= pre_d;
      pim_q           <= pim_d;
      pcnt_q          <= pcnt_d;
      p2_q            <= p2_d;
      p2v_q           <= p2v_d;
      cbuf_q          <= cbuf_d;
      ccnt_q          <= ccnt_d;
      acq_tdata_out   <= acq_d;
      acq_tuser_out   <= acqu_d;
      acq_tvalid_out  <= acqv_d;
      acq_overrun_out <= ovr_d;
    end
  end

  // Transmit chain next state: all but the holding slots step only when the sink pulls
  always_comb begin
    logic [CNT_W-1:0] rlast;
    logic             pop;
    rlast  = CNT_W'((8'h01 << interp_stages_in) - 8'h01);
    pop    = 1'b0;
    uacc_d = uacc_q;
    cur_d  = cur_q;
    curv_d = curv_q;
    nxt_d  = nxt_q;
    nxtv_d = nxtv_q;
    rep_d  = rep_q;
    prev_d = prev_q;
    i5_d   = i5_q;
    dac_d  = dac_tdata_out;
    if (dac_tready_in) begin
      uacc_d = PH_W'(uacc_q + PH_W'(PH_W'(PHASES) * uc_step_in));
      dac_d  = dac_w;
      i5_d   = i5_w;
      prev_d = tx_smp;
      // Each held sample is repeated 2^N times before the next one is used
      if (!curv_q || rep_q == rlast) begin
        pop   = 1'b1;
        rep_d = '0;
      end else begin
        rep_d = CNT_W'(rep_q + 1'b1);
      end
    end
    if (pop) begin
      cur_d  = nxt_q;
      curv_d = nxtv_q;
      nxtv_d = 1'b0;
    end
    // A sample is taken only under the ready we offered
    if (str_tvalid_in && str_tready_out) begin
      if (!curv_d) begin
        cur_d  = str_tdata_in;
        curv_d = 1'b1;
      end else begin
        nxt_d  = str_tdata_in;
        nxtv_d = 1'b1;
      end
    end
    // Two slots let N of zero run one sample per clock with a registered ready
    strr_d = ~nxtv_d;
  end

  // Transmit registers; valid toward the converter stays high, ready does the pacing
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      uacc_q         <= '0;
      cur_q          <= '0;
      curv_q         <= 1'b0;
      nxt_q          <= '0;
      nxtv_q         <= 1'b0;
      rep_q          <= '0;
      prev_q         <= '0;
      i5_q           <= '0;
      str_tready_out <= 1'b0;
      dac_tdata_out  <= '0;
      dac_tvalid_out <= 1'b0;
    end else begin
      uacc_q         <= uacc_d;
      cur_q          <= cur_d;
      curv_q         <= curv_d;
      nxt_q          <= nxt_d;
      nxtv_q         <= nxtv_d;
      rep_q          <= rep_d;
      prev_q         <= prev_d;
      i5_q           <= i5_d;
      str_tready_out <= strr_d;
      dac_tdata_out  <= dac_d;
      dac_tvalid_out <= 1'b1;
    end
  end

endmodule

// ---- sim/dcs_chain_chk.sv ----
`timescale 1ns/10ps
module dcs_chain_chk import dcs_pkg::*; (
  input  wire logic               core_clk_in,
  input  wire logic               nrst_in,
  input  wire logic [STAGE_W-1:0] interp_stages_in,
  input  wire logic               adc_tready_out,
  input  wire logic               acq_tuser_out,
  input  wire logic               acq_tvalid_out,
  input  wire logic               acq_tready_in,
  input  wire logic               acq_overrun_out,
  input  wire logic               str_tvalid_in,
  input  wire logic               str_tready_out,
  input  wire dcs_real5_t         dac_tdata_out,
  input  wire logic               dac_tvalid_out,
  input  wire logic               dac_tready_in
);
  logic seen_q;
  logic last_q;
  // Previous side-band flag, so alternation can be judged word by word
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      seen_q <= 1'b0;
      last_q <= 1'b0;
    end else if (acq_tvalid_out) begin
      seen_q <= 1'b1;
      last_q <= acq_tuser_out;
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // A take while the sink stalls, so nothing leaves the holding slots
  sequence s_take_stalled;
    str_tvalid_in && str_tready_out && !dac_tready_in;
  endsequence
  a_adc_never_stall: assert property ($past(nrst_in) |-> adc_tready_out)
    else $error("receive ready dropped");
  a_dac_always_valid: assert property ($past(nrst_in) |-> dac_tvalid_out)
    else $error("transmit valid dropped");
  a_acq_single_pulse: assert property (acq_tvalid_out |=> !acq_tvalid_out)
    else $error("acquisition words too close");
  a_split_flag_toggle: assert property (acq_tvalid_out |->
    acq_tuser_out == (seen_q ? !last_q : SPLIT_AT_MSB))
    else $error("side-band flag out of order");
  a_overrun_set: assert property (acq_tvalid_out && !acq_tready_in |=> acq_overrun_out)
    else $error("overrun not flagged");
  a_overrun_sticky: assert property (acq_overrun_out |=> acq_overrun_out)
    else $error("overrun flag cleared");
  a_dac_hold_stall: assert property (!dac_tready_in |=> $stable(dac_tdata_out))
    else $error("transmit word moved while stalled");
  a_str_slots_full: assert property (s_take_stalled ##1 s_take_stalled |=> !str_tready_out)
    else $error("streamer still accepted with both slots full");
  a_str_keeps_pace: assert property (dac_tready_in && interp_stages_in == 3'h0
    && str_tready_out |=> str_tready_out)
    else $error("streamer ready lost at full rate");
endmodule

bind dcs_sample_chain dcs_chain_chk u_chk (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
  .interp_stages_in(interp_stages_in), .adc_tready_out(adc_tready_out),
  .acq_tuser_out(acq_tuser_out), .acq_tvalid_out(acq_tvalid_out),
  .acq_tready_in(acq_tready_in), .acq_overrun_out(acq_overrun_out),
  .str_tvalid_in(str_tvalid_in), .str_tready_out(str_tready_out),
  .dac_tdata_out(dac_tdata_out), .dac_tvalid_out(dac_tvalid_out),
  .dac_tready_in(dac_tready_in));

// ---- sim/dcs_str_model.sv ----
`timescale 1ns/10ps
module dcs_str_model import dcs_pkg::*; (
  input  wire logic      clk_in,
  input  wire logic      nrst_in,
  input  wire logic      tready_in,
  input  wire logic      slow_in,
  input  wire dcs_cplx_t value_in,
  output dcs_cplx_t      tdata_out,
  output logic           tvalid_out
);
  logic took_q = 1'b0;
  int   gap    = 0;
  initial begin
    tvalid_out = 1'b0;
    tdata_out  = '0;
  end
  // Note a transfer at the rising edge
  always @(posedge clk_in) took_q <= tvalid_out && tready_in;
  // Lines change half a cycle after the edge; released lines toggle, never keep old data
  always @(negedge clk_in) begin
    if (took_q && slow_in) gap = $urandom_range(2);
    if (!nrst_in || gap != 0) begin
      tvalid_out <= 1'b0;
      tdata_out  <= ~tdata_out;
      if (gap != 0) gap = gap - 1;
    end else begin
      tvalid_out <= 1'b1;
      tdata_out  <= value_in;
    end
  end
endmodule

// ---- sim/ddc_duc_sample_chain_tb_top.sv ----
`timescale 1ns/10ps
module ddc_duc_sample_chain_tb_top import dcs_pkg::*;;
  logic               core_clk_in = 1'b0;
  logic               nrst_in = 1'b0;
  logic               adc_tvalid_in = 1'b0;
  logic               acq_tready_in = 1'b1;
  logic               dac_tready_in = 1'b0;
  logic               slow = 1'b0;
  logic [PH_W-1:0]    dc_step_in = '0;
  logic [PH_W-1:0]    uc_step_in = '0;
  logic [STAGE_W-1:0] decim_stages_in = '0;
  logic [STAGE_W-1:0] interp_stages_in = '0;
  dcs_real5_t         adc_tdata_in = '0;
  dcs_real5_t         dac_tdata_out;
  dcs_cplx_t          str_tdata_in;
  dcs_cplx_t          str_val = '0;
  logic [WORD_W-1:0]  acq_tdata_out;
  logic [WORD_W-1:0]  w;
  logic               acq_tuser_out, acq_tvalid_out, acq_overrun_out, adc_tready_out;
  logic               str_tvalid_in, str_tready_out, dac_tvalid_out;
  logic               exp_tu = 1'b0;
  logic               exp_ovr = 1'b0;
  logic [15:0]        expq [$];
  int                 n_fail = 0, n_checks = 0, cyc = 0, adv = 0, takes = 0;

  dcs_sample_chain dut (.core_clk_in, .nrst_in, .dc_step_in, .uc_step_in, .decim_stages_in,
    .interp_stages_in, .adc_tdata_in, .adc_tvalid_in, .adc_tready_out, .acq_tdata_out,
    .acq_tuser_out, .acq_tvalid_out, .acq_tready_in, .acq_overrun_out, .str_tdata_in,
    .str_tvalid_in, .str_tready_out, .dac_tdata_out, .dac_tvalid_out, .dac_tready_in);
  dcs_str_model u_str (.clk_in(core_clk_in), .nrst_in, .tready_in(str_tready_out),
    .slow_in(slow), .value_in(str_val), .tdata_out(str_tdata_in), .tvalid_out(str_tvalid_in));

  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end
  // Oscillator cosine at whole quarter turns; minus sine is the next quarter up
  function automatic int cq(input int q);
    return (q % 4 == 0) ? 32767 : ((q % 4 == 2) ? -32767 : 0);
  endfunction
  // Word j mixed per phase, truncated, then averaged with the one-fifth gain; {im, re}
  function automatic logic [31:0] dec5(input int x, input int j, input int st);
    int r;
    int i;
    r = 0;
    i = 0;
    for (int k = 0; k < 5; k++) begin
      r += (x * cq((5 * j + k) * st)) >>> 15;
      i += (x * cq((5 * j + k) * st + 1)) >>> 15;
    end
    return {16'((i * 32'sh0000_3333) >>> 16), 16'((r * 32'sh0000_3333) >>> 16)};
  endfunction
  // Five transmit phases after advance a: real part of the sample times the oscillator
  function automatic logic [79:0] dac_exp(input int re, input int im, input int a, input int st);
    logic [79:0] w5;
    for (int k = 0; k < 5; k++)
      w5[16*k+:16] = 16'((re * cq((5 * a + k) * st) + im * cq((5 * a + k) * st + 1)) >>> 15);
    return w5;
  endfunction
  task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    @(negedge core_clk_in);
    nrst_in = 1'b0;
    repeat (12) @(negedge core_clk_in);
    nrst_in = 1'b1;
    expq.delete();
    exp_tu = 1'b0;
    exp_ovr = 1'b0;
    adv = 0;
    takes = 0;
  endtask
  // Score words and count traffic on pre-edge values; the cycle ceiling cuts a hang
  always @(posedge core_clk_in) begin
    cyc++;
    if (nrst_in && acq_tvalid_out === 1'b1) begin
      for (int i = 0; i < 5; i++) w[16*i+:16] = (expq.size() > 0) ? expq.pop_front() : 'x;
      chk(acq_tdata_out, w, "acq word");
      chk(80'(acq_tuser_out), 80'(exp_tu), "acq flag");
      exp_tu = ~exp_tu;
      if (!acq_tready_in) exp_ovr = 1'b1;
    end
    if (nrst_in && dac_tready_in) adv++;
    if (nrst_in && str_tvalid_in && str_tready_out) takes++;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end
  // Receive: random words with gaps; fixed value when the boxcar averages several
  task automatic rx_test(input int n, input int xfix, input logic [15:0] step);
    int x;
    int v;
    logic [31:0] e;
    v = 0;
    decim_stages_in = 3'(n);
    dc_step_in = step;
    do_reset();
    for (int k = 0; k < 60; k++) begin
      x = (n == 0) ? int'($urandom_range(16383)) - 8192 : xfix;
      adc_tdata_in = {5{16'(x)}};
      adc_tvalid_in = ($urandom_range(3) != 0);
      acq_tready_in = ($urandom_range(7) != 0);
      if (adc_tvalid_in) begin
        if (v % (1 << n) == 0) begin
          e = dec5(x, v, int'(step >> 14));
          expq.push_back(e[15:0]);
          expq.push_back(e[31:16]);
        end
        v++;
      end
      @(negedge core_clk_in);
    end
    adc_tvalid_in = 1'b0;
    acq_tready_in = 1'b1;
    repeat (8) @(negedge core_clk_in);
    chk(80'(acq_overrun_out), 80'(exp_ovr), "overrun");
    $display("receive test stages %0d done", n);
  endtask
  // Transmit: constant sample, sink stalls first, then random pulls
  task automatic tx_test(input int n, input logic slw);
    int c;
    int ci;
    int st;
    c = int'($urandom_range(16383)) - 8192;
    interp_stages_in = 3'(n);
    uc_step_in = (n % 2 != 0) ? 16'h4000 : 16'h0000;
    st = n % 2;
    slow = slw;
    str_val = {16'($urandom), 16'(c)};
    ci = int'(str_val.im);
    do_reset();
    for (int k = 0; k < 150; k++) begin
      dac_tready_in = (k >= 4) && ($urandom_range(4) != 0);
      @(negedge core_clk_in);
      if (adv > 3 * (1 << n) + 4)
        chk(dac_tdata_out, dac_exp(c, ci, adv - 1, st), "dac word");
    end
    if (!slw) chk(80'(takes - (adv >> n) inside {[-1:3]}), 80'(1), "pull rate");
    dac_tready_in = 1'b0;
    $display("transmit test stages %0d done", n);
  endtask
  initial begin
    void'($urandom(93));
    rx_test(0, 0, 16'h4000);
    rx_test(1, 8191, 16'h0000);
    rx_test(3, -8192, 16'h0000);
    for (int n = 0; n < 4; n++) tx_test(n, n > 1);
    print_verdict();
  end
endmodule
